// ---- verilog/tdsw_pkg.sv ----
`default_nettype none
package tdsw_pkg;

  // descriptor layout inside the ring
  localparam logic [23:0] DESC_W0_OFF   = 24'h000000; // buffer address low
  localparam logic [23:0] DESC_W1_OFF   = 24'h000002; // status word
  localparam logic [23:0] DESC_W2_OFF   = 24'h000004; // length word
  localparam int          DESC_SHIFT    = 3;          // eight bytes per descriptor

  // status word field positions
  localparam int OWN_BIT        = 15;
  localparam int ERR_BIT        = 14;
  localparam int SPARE_BIT      = 13;
  localparam int MULTI_BIT      = 12;
  localparam int SINGLE_BIT     = 11;
  localparam int WAITED_BIT     = 10;
  localparam int FIRST_BIT      = 9;
  localparam int LAST_BIT       = 8;
  localparam int BASE_HIGH_MSB  = 7;

  // length word field positions and checks
  localparam int          LEN_MSB       = 11;
  localparam logic [3:0]  LEN_TOP_ONES  = 4'hf;
  localparam logic [11:0] LEN_MIN_BYTES = 12'h040;    // 64
  localparam logic [11:0] LEN_MAX_BYTES = 12'h5ee;    // 1518

  // reset values
  localparam logic [15:0] WORD_RST      = 16'h0000;
  localparam logic [23:0] ADDR_RST      = 24'h000000;

  // one shared buffer ram access
  typedef struct packed {
    logic        we;     // high for a write
    logic [23:0] addr;   // byte address of a 16-bit word
    logic [15:0] wdata;  // write data
  } tdsw_mem_cmd_t;

  // buffer handed to the transmitter
  typedef struct packed {
    logic [23:0] addr;   // buffer start
    logic [11:0] len;    // byte count, positive
    logic        first;  // first buffer of packet
    logic        last;   // last buffer of packet
  } tdsw_buf_info_t;

  // outcome reported by the transmitter
  typedef struct packed {
    logic [4:0] retries;       // retries needed
    logic       waited;        // line was busy when ready
    logic       late_collision_flag;
    logic       carrier_loss_flag;
    logic       underflow_flag;
    logic       retry_limit_flag;
  } tdsw_tx_status_t;

  // byte address of one word of descriptor idx
  function automatic logic [23:0] desc_addr(input logic [23:0] base,
                                            input logic [6:0]  idx,
                                            input logic [23:0] off);
    logic [23:0] ofs;
    ofs = {14'h0000, idx, 3'h0};
    desc_addr = base + ofs + off;
  endfunction

endpackage
`default_nettype wire

// ---- verilog/tdsw_ring_ptr.sv ----
`timescale 1ns/1ps
`default_nettype none
module tdsw_ring_ptr #(
  parameter int IDX_W = 7
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             init,        // back to ring start
  input  wire logic             advance,     // one-cycle step
  input  wire logic [2:0]       len_log2,    // ring holds 2**len_log2 entries
  output logic      [IDX_W-1:0] idx
);

  logic [IDX_W-1:0] idx_q;  // current entry
  logic [IDX_W-1:0] mask;   // entries minus one
  logic [IDX_W-1:0] one;    // increment

  assign one  = {{(IDX_W-1){1'b0}}, 1'b1};
  assign mask = (one << len_log2) - one;
  assign idx  = idx_q;

  // init wins; wrap by masking instead of a compare to ring size
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      idx_q <= '0;
    else if (ce)
    begin
      if (init)
        idx_q <= '0;
      else if (advance)
        idx_q <= (idx_q + one) & mask;
    end
  end

endmodule // tdsw_ring_ptr
`default_nettype wire

// ---- verilog/tdsw_status_merge.sv ----
`timescale 1ns/1ps
`default_nettype none
module tdsw_status_merge (
  input  wire logic                     [15:0] word_in,  // status word as fetched
  input  wire tdsw_pkg::tdsw_tx_status_t       st,       // transmit outcome
  output logic                          [15:0] word_out  // word to write back
);

  logic err_sum;  // any hard failure

  assign err_sum = st.late_collision_flag | st.carrier_loss_flag
                 | st.underflow_flag | st.retry_limit_flag;

  // host-owned marks and address byte pass through; flags stay sticky until host clears
  always_comb
  begin
    word_out = word_in;
    word_out[tdsw_pkg::OWN_BIT]    = 1'b0;
    word_out[tdsw_pkg::ERR_BIT]    = word_in[tdsw_pkg::ERR_BIT] | err_sum;
    word_out[tdsw_pkg::SPARE_BIT]  = 1'b0;
    word_out[tdsw_pkg::MULTI_BIT]  = word_in[tdsw_pkg::MULTI_BIT]
                                   | (st.retries > 5'h01);
    word_out[tdsw_pkg::SINGLE_BIT] = word_in[tdsw_pkg::SINGLE_BIT]
                                   | (st.retries == 5'h01);
    word_out[tdsw_pkg::WAITED_BIT] = word_in[tdsw_pkg::WAITED_BIT] | st.waited;
  end

endmodule // tdsw_status_merge
`default_nettype wire

// ---- verilog/tdsw_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module tdsw_engine #(
  parameter int IDX_W = 7
) (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      ce,           // freezes all state when low
  input  wire logic                      init,         // pulse: pointer to ring start
  input  wire logic                      poll_req,     // pulse: look at current entry
  input  wire logic               [23:0] tx_ring_base, // ring start, bits 2..0 zero
  input  wire logic               [2:0]  ring_len_log2,
  output logic                           mem_req,      // access pending
  output tdsw_pkg::tdsw_mem_cmd_t        mem_cmd,      // access, from flops
  input  wire logic                      mem_ack,      // access done this cycle
  input  wire logic               [15:0] mem_rdata,    // read data with mem_ack
  output logic                           buf_valid,    // buffer offered
  output tdsw_pkg::tdsw_buf_info_t       buf_info,     // offered buffer, from flops
  input  wire logic                      buf_taken,    // transmitter took it
  input  wire logic                      tx_done,      // pulse: buffer finished
  input  wire tdsw_pkg::tdsw_tx_status_t tx_status,    // outcome with tx_done
  output logic               [IDX_W-1:0] ring_index,   // current entry
  output logic                           busy,         // not idle
  output logic                           fmt_warn      // last length word malformed
);

  // descriptor walk; word1 first so an unowned entry costs one read
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,  // waiting for a poll
    ST_RD_W1   = 3'b001,  // fetch status word
    ST_RD_W0   = 3'b010,  // fetch address low
    ST_RD_W2   = 3'b011,  // fetch length word
    ST_OFFER   = 3'b100,  // buffer on offer
    ST_WAIT_TX = 3'b101,  // transmitter busy
    ST_WR_W1   = 3'b110,  // write status back
    ST_ADV     = 3'b111   // step ring pointer
  } tdsw_state_t;

  tdsw_state_t              state_q;       // current state
  tdsw_state_t              state_d;       // next state
  logic              [15:0] word1_q;       // status word as fetched
  logic              [15:0] word1_wr_q;    // status word to write back
  logic              [15:0] word1_new;     // merged status word
  logic              [15:0] addr_low_q;    // address bits 15..0
  tdsw_pkg::tdsw_mem_cmd_t  mem_cmd_q;     // registered access
  tdsw_pkg::tdsw_mem_cmd_t  cmd_d;         // access for next state
  tdsw_pkg::tdsw_buf_info_t buf_info_q;    // offered buffer
  logic                     fmt_warn_q;    // malformed length word seen
  logic                     poll_pend_q;   // poll arrived while busy
  logic                     chain_q;       // packet continues in next entry
  logic                     advance;       // step pointer this cycle
  logic              [11:0] len_pos;       // positive byte count
  logic              [IDX_W-1:0] idx;      // current entry
  logic              [6:0]  idx7;          // entry widened for address math
  logic              [IDX_W-1:0] idx_mask; // entries minus one
  logic              [IDX_W-1:0] idx_nx;   // entry the next access belongs to

  // ring pointer moves only after ownership went back
  tdsw_ring_ptr #(
    .IDX_W    (IDX_W)
  ) u_ptr (
    .clock    (clock),
    .rstn     (rstn),
    .ce       (ce),
    .init     (init),
    .advance  (advance),
    .len_log2 (ring_len_log2),
    .idx      (idx)
  );

  // status bits for the write back
  // pure logic; the register that holds its result sits in this module
  tdsw_status_merge u_merge (
    .word_in  (word1_q),
    .st       (tx_status),
    .word_out (word1_new)
  );

  // the pointer steps on the same edge that issues a chained fetch, so the
  // address must use the entry the pointer is about to hold, not the old one
  assign idx_mask = IDX_W'((32'h1 << ring_len_log2) - 32'h1);
  assign idx_nx   = init ? '0 : (advance ? ((idx + IDX_W'(1)) & idx_mask) : idx);
  assign idx7     = 7'(idx_nx);
  assign advance = (state_q == ST_ADV);
  assign len_pos = 12'(~mem_rdata[tdsw_pkg::LEN_MSB:0] + 12'h001);

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        // an init drops the walk so the pointer and the fetch agree
        if ((poll_req || poll_pend_q) && !init)
          state_d = ST_RD_W1;
      end
      ST_RD_W1:
      begin
        if (mem_ack)
        begin
          // not ours: leave it alone and keep the pointer
          if (mem_rdata[tdsw_pkg::OWN_BIT])
            state_d = ST_RD_W0;
          else
            state_d = ST_IDLE;
        end
      end
      ST_RD_W0:
      begin
        if (mem_ack)
          state_d = ST_RD_W2;
      end
      ST_RD_W2:
      begin
        if (mem_ack)
          state_d = ST_OFFER;
      end
      ST_OFFER:
      begin
        // the offer stands until taken; the transmitter sets the pace
        if (buf_taken)
          state_d = ST_WAIT_TX;
      end
      ST_WAIT_TX:
      begin
        // tx_done in any other state belongs to no buffer and is dropped
        if (tx_done)
          state_d = ST_WR_W1;
      end
      ST_WR_W1:
      begin
        if (mem_ack)
          state_d = ST_ADV;
      end
      ST_ADV:
      begin
        // a chained packet goes straight on to the next entry
        if (chain_q || poll_pend_q)
          state_d = ST_RD_W1;
        else
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // state register
  // ce low parks the walk wherever it is; the ram must keep its answer up
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state_q <= ST_IDLE;
    else if (ce)
      state_q <= state_d;
  end

  // access to issue in the state about to be entered
  always_comb
  begin
    cmd_d.we    = 1'b0;
    cmd_d.wdata = tdsw_pkg::WORD_RST;
    cmd_d.addr  = tdsw_pkg::ADDR_RST;
    case (state_d)
      ST_RD_W1:
        cmd_d.addr = tdsw_pkg::desc_addr(tx_ring_base, idx7, tdsw_pkg::DESC_W1_OFF);
      ST_RD_W0:
        cmd_d.addr = tdsw_pkg::desc_addr(tx_ring_base, idx7, tdsw_pkg::DESC_W0_OFF);
      ST_RD_W2:
        cmd_d.addr = tdsw_pkg::desc_addr(tx_ring_base, idx7, tdsw_pkg::DESC_W2_OFF);
      ST_WR_W1:
      begin
        // one word write: ownership flips together with the last status change
        cmd_d.we    = 1'b1;
        cmd_d.addr  = tdsw_pkg::desc_addr(tx_ring_base, idx7, tdsw_pkg::DESC_W1_OFF);
        // the merged word is registered on the edge that raises the request,
        // so the first cycle takes it straight from the merge
        cmd_d.wdata = (state_q == ST_WR_W1) ? word1_wr_q : word1_new;
      end
      default:
        cmd_d.we = 1'b0;
    endcase
  end

  // access register; steady while the ram holds off mem_ack
  // reloaded each cycle: cmd_d repeats the same access until the answer
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_cmd_q.we    <= 1'b0;
      mem_cmd_q.addr  <= tdsw_pkg::ADDR_RST;
      mem_cmd_q.wdata <= tdsw_pkg::WORD_RST;
    end
    else if (ce)
      mem_cmd_q <= cmd_d;
  end

  // fetched status word, kept for the write back
  // host edits after handover are never seen: only this copy is merged
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      word1_q <= tdsw_pkg::WORD_RST;
    else if (ce && state_q == ST_RD_W1 && mem_ack)
      word1_q <= mem_rdata;
  end

  // outcome folded in when the transmitter finishes
  // it feeds the write request from its second cycle on
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      word1_wr_q <= tdsw_pkg::WORD_RST;
    else if (ce && state_q == ST_WAIT_TX && tx_done)
      word1_wr_q <= word1_new;
  end

  // address low half
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      addr_low_q <= tdsw_pkg::WORD_RST;
    else if (ce && state_q == ST_RD_W0 && mem_ack)
      addr_low_q <= mem_rdata;
  end

  // buffer description built once the length word arrives
  // it stays steady through the offer and the transmission
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      buf_info_q.addr  <= tdsw_pkg::ADDR_RST;
      buf_info_q.len   <= 12'h000;
      buf_info_q.first <= 1'b0;
      buf_info_q.last  <= 1'b0;
    end
    else if (ce && state_q == ST_RD_W2 && mem_ack)
    begin
      buf_info_q.addr  <= {word1_q[tdsw_pkg::BASE_HIGH_MSB:0], addr_low_q};
      buf_info_q.len   <= len_pos;
      buf_info_q.first <= word1_q[tdsw_pkg::FIRST_BIT];
      buf_info_q.last  <= word1_q[tdsw_pkg::LAST_BIT];
    end
  end

  // malformed length word: flagged only, the walk goes on since the host owns the format
  // a short buffer may leave the transmitter too little time to chain
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      fmt_warn_q <= 1'b0;
    else if (ce && state_q == ST_RD_W2 && mem_ack)
      fmt_warn_q <= (mem_rdata[15:12] != tdsw_pkg::LEN_TOP_ONES)
                  || (len_pos < tdsw_pkg::LEN_MIN_BYTES)
                  || (len_pos > tdsw_pkg::LEN_MAX_BYTES);
  end

  // chaining: a buffer without the last mark continues in the next entry
  // init wins so a walk restarted at the ring start never chains on
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      chain_q <= 1'b0;
    else if (ce)
    begin
      if (init)
        chain_q <= 1'b0;
      else if (state_q == ST_WR_W1 && mem_ack)
        chain_q <= ~word1_q[tdsw_pkg::LAST_BIT];
      else if (state_q == ST_ADV)
        chain_q <= 1'b0;
    end
  end

  // poll memory; a poll in the cycle of the clear is kept
  // it is cleared when a fetch starts, so one poll looks at one entry
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      poll_pend_q <= 1'b0;
    else if (ce)
    begin
      if (poll_req)
        poll_pend_q <= 1'b1;
      else if (init || state_q == ST_RD_W1)
        poll_pend_q <= 1'b0;
    end
  end

  // handshake outputs straight from the state, data outputs from flops
  assign mem_req    = (state_q == ST_RD_W1) || (state_q == ST_RD_W0)
                   || (state_q == ST_RD_W2) || (state_q == ST_WR_W1);
  assign mem_cmd    = mem_cmd_q;
  assign buf_valid  = (state_q == ST_OFFER);
  assign buf_info   = buf_info_q;
  assign ring_index = idx;
  assign busy       = (state_q != ST_IDLE);
  assign fmt_warn   = fmt_warn_q;

endmodule // tdsw_engine
`default_nettype wire

// ---- dv/tdsw_engine_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module tdsw_engine_sva #(
  parameter int IDX_W = 7
) (
  input wire logic                      clock,
  input wire logic                      rstn,
  input wire logic [23:0]               tx_ring_base,
  input wire logic [2:0]                ring_len_log2,
  input wire logic                      mem_req,
  input wire tdsw_pkg::tdsw_mem_cmd_t   mem_cmd,
  input wire logic                      mem_ack,
  input wire logic [15:0]               mem_rdata,
  input wire logic                      buf_valid,
  input wire tdsw_pkg::tdsw_buf_info_t  buf_info,
  input wire logic                      tx_done,
  input wire tdsw_pkg::tdsw_tx_status_t tx_status,
  input wire logic                      busy,
  input wire logic [IDX_W-1:0]          ring_index
);
  logic [15:0]               w0_q, w1_q, w2_q; // words fetched for this entry
  tdsw_pkg::tdsw_tx_status_t st_q;             // outcome of this buffer
  logic [IDX_W-1:0]          nxt_q;            // index due after release
  logic                      rd_ack;           // a read completes now
  assign rd_ack = mem_req && mem_ack && !mem_cmd.we;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // copies need no reset: each is loaded before a property reads it
  always_ff @(posedge clock)
  begin
    if (rd_ack && mem_cmd.addr[2:0] == 3'h0) w0_q <= mem_rdata;
    if (rd_ack && mem_cmd.addr[2:0] == 3'h2) w1_q <= mem_rdata;
    if (rd_ack && mem_cmd.addr[2:0] == 3'h4) w2_q <= mem_rdata;
    // outcome counts whenever busy with no offer and no access pending
    if (tx_done && busy && !buf_valid && !mem_req) st_q <= tx_status;
    if (mem_req && mem_ack && mem_cmd.we)
      nxt_q <= IDX_W'((ring_index + 1) & ((1 << ring_len_log2) - 1));
  end
  sequence s_w1_ack; rd_ack && mem_cmd.addr[2:0] == 3'h2; endsequence
  sequence s_wb; mem_req && mem_cmd.we; endsequence
  property p_own;
    s_w1_ack ##0 !mem_rdata[15] |=> !(mem_req && mem_cmd.addr[2:0] == 3'h0);
  endproperty
  a_own: assert property (p_own) else $error("unowned entry fetched further");
  property p_rd_addr;
    mem_req && !mem_cmd.we && mem_cmd.addr[2:0] == 3'h2
      |-> mem_cmd.addr == tx_ring_base + (24'(ring_index) << 3) + 24'h000002;
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("status word address wrong");
  property p_buf;
    buf_valid |-> buf_info.addr == {w1_q[7:0], w0_q}
      && buf_info.first == w1_q[9] && buf_info.last == w1_q[8];
  endproperty
  a_buf: assert property (p_buf) else $error("offered buffer wrong");
  property p_len;
    buf_valid |-> buf_info.len == 12'(-w2_q[11:0]);
  endproperty
  a_len: assert property (p_len) else $error("offered length wrong");
  property p_wb_own;
    s_wb |-> !mem_cmd.wdata[15] && mem_cmd.addr[2:0] == 3'h2;
  endproperty
  a_wb_own: assert property (p_wb_own) else $error("release keeps ownership");
  property p_err;
    s_wb |-> mem_cmd.wdata[14] == (w1_q[14] | st_q.late_collision_flag
      | st_q.carrier_loss_flag | st_q.underflow_flag | st_q.retry_limit_flag);
  endproperty
  a_err: assert property (p_err) else $error("error summary wrong");
  property p_spare;
    s_wb |-> !mem_cmd.wdata[13];
  endproperty
  a_spare: assert property (p_spare) else $error("spare bit written one");
  property p_retry;
    s_wb |-> mem_cmd.wdata[12:10] == (w1_q[12:10]
      | {st_q.retries > 5'h01, st_q.retries == 5'h01, st_q.waited});
  endproperty
  a_retry: assert property (p_retry) else $error("retry flags wrong");
  property p_keep;
    s_wb |-> mem_cmd.wdata[9:0] == w1_q[9:0];
  endproperty
  a_keep: assert property (p_keep) else $error("host fields altered");
  property p_adv;
    s_wb ##0 mem_ack |-> ##2 ring_index == nxt_q;
  endproperty
  a_adv: assert property (p_adv) else $error("ring index not advanced");
endmodule // tdsw_engine_sva

bind tdsw_engine tdsw_engine_sva #(.IDX_W(IDX_W)) i_tdsw_engine_sva (
  .clock(clock), .rstn(rstn), .tx_ring_base(tx_ring_base),
  .ring_len_log2(ring_len_log2), .mem_req(mem_req), .mem_cmd(mem_cmd),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata), .buf_valid(buf_valid),
  .buf_info(buf_info), .tx_done(tx_done), .tx_status(tx_status),
  .busy(busy), .ring_index(ring_index));
`default_nettype wire

// ---- dv/tdsw_ram_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tdsw_ram_model #(
  parameter int BASE_W = 8 // word index of the ring start
) (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic [1:0]              lat,       // extra wait cycles
  input  wire logic                    mem_req,
  input  wire tdsw_pkg::tdsw_mem_cmd_t mem_cmd,
  output logic                         mem_ack,
  output logic [15:0]                  mem_rdata
);
  logic [15:0] mem [0:255]; // shared ram, word addressed
  logic [1:0]  cnt_q;       // cycles waited on this access
  logic [7:0]  wa;          // word address of the request
  assign wa = mem_cmd.addr[8:1];
  // data lines toggle unless an access is answered, so late sampling shows
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_ack   <= 1'b0;
      cnt_q     <= 2'h0;
      mem_rdata <= 16'h0000;
    end
    else if (mem_ack)
    begin
      mem_ack   <= 1'b0;
      cnt_q     <= 2'h0;
      mem_rdata <= ~mem_rdata;
    end
    else if (mem_req && cnt_q >= lat)
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[wa];
      if (mem_cmd.we) mem[wa] <= mem_cmd.wdata;
    end
    else
    begin
      cnt_q     <= cnt_q + (mem_req ? 2'h1 : 2'h0);
      mem_rdata <= ~mem_rdata;
    end
  end
  // host software prepares an entry; the status word goes last
  task automatic build(input int n, input logic [7:0] up, input logic [7:0] hi,
                       input logic [15:0] lo, input logic [11:0] len);
    mem[BASE_W + 4 * n]     = lo;
    mem[BASE_W + 4 * n + 2] = {4'hf, 12'(-len)};
    mem[BASE_W + 4 * n + 1] = {up, hi};
  endtask
endmodule // tdsw_ram_model
`default_nettype wire

// ---- dv/tdsw_engine_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tdsw_engine_tb;
  logic                      clock, rstn, poll_req, buf_taken, tx_done;
  logic [1:0]                lat;       // ram wait cycles
  logic                      mem_req, mem_ack, buf_valid, busy, fmt_warn;
  logic [15:0]               mem_rdata;
  logic [6:0]                ring_index;
  tdsw_pkg::tdsw_mem_cmd_t   mem_cmd;
  tdsw_pkg::tdsw_buf_info_t  buf_info;
  tdsw_pkg::tdsw_tx_status_t tx_status;
  int                        fail_count, compares, i;

  // ring of four entries at byte 0x10
  tdsw_engine #(.IDX_W(7)) i_tdsw_engine (
    .clock(clock), .rstn(rstn), .ce(1'b1), .init(1'b0), .poll_req(poll_req),
    .tx_ring_base(24'h000010), .ring_len_log2(3'h2), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .buf_valid(buf_valid), .buf_info(buf_info), .buf_taken(buf_taken),
    .tx_done(tx_done), .tx_status(tx_status), .ring_index(ring_index),
    .busy(busy), .fmt_warn(fmt_warn));
  tdsw_ram_model i_tdsw_ram_model (
    .clock(clock), .rstn(rstn), .lat(lat), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one-cycle poll, entered and left at a falling edge
  task automatic poll;
    poll_req = 1'b1;
    @(negedge clock);
    poll_req = 1'b0;
    @(negedge clock);
  endtask

  // acts as transmitter: judge the offer, take it, report an outcome
  task automatic xfer(input logic [23:0] ad, input logic [11:0] ln,
                      input logic [1:0] mk, input logic [9:0] st);
    for (i = 0; i < 60 && buf_valid !== 1'b1; i++) @(negedge clock);
    chk("buf_addr", buf_info.addr, ad);
    chk("buf_len", buf_info.len, ln);
    chk("marks", {buf_info.first, buf_info.last}, mk);
    buf_taken = 1'b1;
    @(negedge clock);
    buf_taken = 1'b0;
    tx_status = st;
    tx_done   = 1'b1;
    @(negedge clock);
    tx_done   = 1'b0;
  endtask

  // bounded wait for idle, then the ring position
  task automatic settle(input logic [6:0] idx);
    for (i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clock);
    chk("ring_index", ring_index, idx);
  endtask

  // whole packet, one retry, stale spare bit set by the host
  task automatic t_whole;
    lat = 2'h0;
    i_tdsw_ram_model.build(0, 8'ha3, 8'h0a, 16'h1234, 12'h040);
    poll;
    xfer(24'h0a1234, 12'h040, 2'b11, 10'h020);
    settle(7'h01);
    chk("w1_0", i_tdsw_ram_model.mem[9], 16'h0b0a);
    chk("fmt_warn", fmt_warn, 1'b0);
    $display("test whole packet done");
  endtask

  // two chained buffers on a slow ram, no poll between them
  task automatic t_chain;
    lat = 2'h3;
    i_tdsw_ram_model.build(1, 8'h82, 8'h00, 16'h2000, 12'h5ee);
    i_tdsw_ram_model.build(2, 8'h81, 8'h00, 16'h2800, 12'h064);
    poll;
    xfer(24'h002000, 12'h5ee, 2'b10, 10'h068);
    xfer(24'h002800, 12'h064, 2'b01, 10'h010);
    settle(7'h03);
    chk("w1_1", i_tdsw_ram_model.mem[13], 16'h5200);
    chk("w1_2", i_tdsw_ram_model.mem[17], 16'h0500);
    $display("test chain done");
  endtask

  // entry still held by the host: nothing moves
  task automatic t_idle;
    i_tdsw_ram_model.build(3, 8'h01, 8'h00, 16'h0000, 12'h040);
    poll;
    settle(7'h03);
    chk("w1_3", i_tdsw_ram_model.mem[21], 16'h0100);
    $display("test host owned done");
  endtask

  // last entry wraps the ring; host-set error summary kept
  task automatic t_wrap;
    lat = 2'h1;
    i_tdsw_ram_model.build(3, 8'hc1, 8'h05, 16'h0000, 12'h400);
    // host slip: top nibble of the length word left clear, still sent
    i_tdsw_ram_model.mem[22] = 16'h0c00;
    poll;
    xfer(24'h050000, 12'h400, 2'b01, 10'h003);
    settle(7'h00);
    chk("w1_3", i_tdsw_ram_model.mem[21], 16'h4105);
    chk("fmt_warn", fmt_warn, 1'b1);
    $display("test wrap done");
  endtask

  initial
  begin
    rstn       = 1'b0;
    poll_req   = 1'b0;
    buf_taken  = 1'b0;
    tx_done    = 1'b0;
    lat        = 2'h0;
    tx_status  = '0;
    fail_count = 0;
    compares   = 0;
    repeat (5) @(negedge clock);
    chk("reset", {busy, mem_req, buf_valid, fmt_warn, ring_index}, 24'h000000);
    rstn = 1'b1;
    t_whole;
    t_chain;
    t_idle;
    t_wrap;
    end_of_test;
  end

  // all tests need well under 600 cycles
  initial
  begin
    repeat (2000) @(posedge clock);
    $display("ERROR watchdog expired");
    fail_count++;
    end_of_test;
  end
endmodule // tdsw_engine_tb
`default_nettype wire
